// ### rtl/tmr_dual_timer.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Function
// - timer 0 modes: 13-bit, 16-bit, reload, split
// - timer 1 same first modes; code 11 reserved
// - timer 1 clock: cpu/12 or divided oscillator
// - timer 0 clock: cpu/12 or divided oscillator
// - timer 0 oscillator divider 128 down to 1
// - timer 1 oscillator divider 128 down to 1
// - gate bit gates timer 0 by pin
// - timer 1 overflow sets its flag, except in timer 0 split mode
// - timer 0 overflow sets its flag
// - flags clear on service or firmware write
// - timer enables and global enable, reset zero
// - high count bytes read-write, reset zero
// - low count bytes read-write, reset zero
// - 13-bit mode overflows from FF1F to 0000
// - reload mode copies high byte on overflow
// - split mode high byte uses timer 1 controls
// - 16-bit mode overflows from FFFF to 0000
module tmr_dual_timer
    import tmr_pkg::*;
#(
    parameter int CPU_PRESCALE = tmr_pkg::CPU_DIV
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic osc_tick_in,
    input wire logic ext_irq0_pin_in,
    input wire logic timer0_irq_ack_in,
    input wire logic timer1_irq_ack_in,
    output logic [7:0] rd_data_out,
    output logic timer0_irq_req_out,
    output logic timer1_irq_req_out
);
    import tmr_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed
    {
        logic [3:0] cpu_cnt;
        logic timer1_overflow_flag;
        logic timer1_run;
        logic timer0_overflow_flag;
        logic timer0_run;
        logic timer1_clock_select;
        tmr_mode_e timer1_mode_field;
        logic timer0_pin_gating;
        logic timer0_clock_select;
        tmr_mode_e timer0_mode_field;
        logic [2:0] timer0_ext_div_field;
        logic [2:0] timer1_ext_div_field;
        logic global_irq_enable;
        logic timer1_irq_enable;
        logic timer0_irq_enable;
        logic [7:0] timer0_count_high;
        logic [7:0] timer0_count_low;
        logic [7:0] timer1_count_high;
        logic [7:0] timer1_count_low;
        logic [7:0] rd_data;
        logic irq0_req;
        logic irq1_req;
    } tmr_core_s;

    tmr_core_s s_r;
    tmr_core_s s_nxt;

    // ==========================================================
    // clock sources
    // ==========================================================
    logic cpu12_tick;
    logic [1:0] osc_div_tick;
    logic [1:0][2:0] osc_rate;
    logic t0_tick;
    logic t1_tick;
    logic t0_lo_en;
    logic t0_hi_en;
    logic t1_en;
    logic [16:0] t0_step;
    logic [16:0] t1_step;
    logic [8:0] t0_hi_split;
    logic t0_ovf;
    logic t1_ovf;
    logic wr_t0_lo;
    logic wr_t0_hi;
    logic wr_fr;

    assign cpu12_tick =
        (s_r.cpu_cnt == 4'(CPU_PRESCALE - 1));
    assign osc_rate[0] = s_r.timer0_ext_div_field;
    assign osc_rate[1] = s_r.timer1_ext_div_field;

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_osc_div
            tmr_prescale u_pre
            (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .ce_in(ce_in),
                .tick_in(osc_tick_in),
                .rate_in(osc_rate[i]),
                .tick_out(osc_div_tick[i])
            );
        end
    endgenerate

    assign t0_tick = (s_r.timer0_clock_select ? osc_div_tick[0]
        : cpu12_tick)
        && (!s_r.timer0_pin_gating || ext_irq0_pin_in);
    assign t1_tick = s_r.timer1_clock_select ? osc_div_tick[1]
        : cpu12_tick;

    // ==========================================================
    // counting
    // ==========================================================
    // returns {overflow, high, low} after one count
    function automatic logic [16:0] tmr_step(input tmr_mode_e m,
        input logic [7:0] hi, input logic [7:0] lo);
        logic [5:0] c5;
        logic [8:0] c8;
        logic [16:0] c16;
        c5 = {1'b0, lo[4:0]} + 6'h01;
        c8 = {1'b0, lo} + 9'h001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        case (m)
            MODE_13BIT:
                tmr_step = {c5[5] && (hi == BYTE_MAX),
                    c5[5] ? 8'(hi + 8'h01) : hi, lo[7:5], c5[4:0]};
            MODE_16BIT:
                tmr_step = c16;
            MODE_RELOAD:
                tmr_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
            default:
                tmr_step = {c8[8], hi, c8[7:0]};
        endcase
    endfunction : tmr_step

    assign t0_lo_en = s_r.timer0_run && t0_tick;
    assign t0_hi_en = s_r.timer1_run && cpu12_tick;
    assign t1_en = (s_r.timer0_mode_field == MODE_SPLIT)
        ? (s_r.timer1_mode_field != MODE_SPLIT) && t1_tick
        : (s_r.timer1_mode_field != MODE_SPLIT)
            && s_r.timer1_run && t1_tick;
    assign t0_step = tmr_step(s_r.timer0_mode_field,
        s_r.timer0_count_high, s_r.timer0_count_low);
    assign t1_step = tmr_step(s_r.timer1_mode_field,
        s_r.timer1_count_high, s_r.timer1_count_low);
    assign t0_hi_split = {1'b0, s_r.timer0_count_high} + 9'h001;
    assign t0_ovf = t0_lo_en && t0_step[16];
    assign t1_ovf = (s_r.timer0_mode_field == MODE_SPLIT)
        ? t0_hi_en && t0_hi_split[8]
        : t1_en && t1_step[16];

    assign wr_t0_lo = wr_in && (addr_in == ADDR_T0_LOW);
    assign wr_t0_hi = wr_in && (addr_in == ADDR_T0_HIGH);
    assign wr_fr = wr_in && (addr_in == ADDR_FLAGS_RUN);

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.cpu_cnt = cpu12_tick ? 4'h0 : 4'(s_r.cpu_cnt + 4'h1);
        if (t0_lo_en)
        begin
            s_nxt.timer0_count_low = t0_step[7:0];
            if (s_r.timer0_mode_field != MODE_SPLIT)
                s_nxt.timer0_count_high = t0_step[15:8];
        end
        if ((s_r.timer0_mode_field == MODE_SPLIT) && t0_hi_en)
            s_nxt.timer0_count_high = t0_hi_split[7:0];
        if (t1_en)
        begin
            s_nxt.timer1_count_low = t1_step[7:0];
            s_nxt.timer1_count_high = t1_step[15:8];
        end
        // flag clear by service acknowledge
        if (timer0_irq_ack_in)
            s_nxt.timer0_overflow_flag = 1'b0;
        if (timer1_irq_ack_in)
            s_nxt.timer1_overflow_flag = 1'b0;
        // register writes; reserved bits are simply not stored
        if (wr_in)
        begin
            case (addr_in)
                ADDR_FLAGS_RUN:
                begin
                    s_nxt.timer1_overflow_flag = wr_data_in[FR_T1_FLAG];
                    s_nxt.timer1_run = wr_data_in[FR_T1_RUN];
                    s_nxt.timer0_overflow_flag = wr_data_in[FR_T0_FLAG];
                    s_nxt.timer0_run = wr_data_in[FR_T0_RUN];
                end
                ADDR_MODE_SEL:
                begin
                    s_nxt.timer1_clock_select = wr_data_in[MS_T1_CLK];
                    s_nxt.timer1_mode_field =
                        tmr_mode_e'(wr_data_in[MS_T1_MODE+:2]);
                    s_nxt.timer0_pin_gating = wr_data_in[MS_T0_GATE];
                    s_nxt.timer0_clock_select = wr_data_in[MS_T0_CLK];
                    s_nxt.timer0_mode_field =
                        tmr_mode_e'(wr_data_in[MS_T0_MODE+:2]);
                end
                ADDR_T0_LOW: s_nxt.timer0_count_low = wr_data_in;
                ADDR_T1_LOW: s_nxt.timer1_count_low = wr_data_in;
                ADDR_T0_HIGH: s_nxt.timer0_count_high = wr_data_in;
                ADDR_T1_HIGH: s_nxt.timer1_count_high = wr_data_in;
                ADDR_IRQ_EN:
                begin
                    s_nxt.global_irq_enable = wr_data_in[IE_GLOBAL];
                    s_nxt.timer1_irq_enable = wr_data_in[IE_T1];
                    s_nxt.timer0_irq_enable = wr_data_in[IE_T0];
                end
                ADDR_EXT_DIV:
                begin
                    s_nxt.timer0_ext_div_field =
                        wr_data_in[DV_T0_RATE+:RATE_W];
                    s_nxt.timer1_ext_div_field =
                        wr_data_in[DV_T1_RATE+:RATE_W];
                end
                default: ;
            endcase
        end
        // a hardware overflow wins over any clear in the same cycle
        if (t0_ovf)
            s_nxt.timer0_overflow_flag = 1'b1;
        if (t1_ovf)
            s_nxt.timer1_overflow_flag = 1'b1;
        s_nxt.irq0_req = s_nxt.timer0_overflow_flag
            && s_nxt.timer0_irq_enable && s_nxt.global_irq_enable;
        s_nxt.irq1_req = s_nxt.timer1_overflow_flag
            && s_nxt.timer1_irq_enable && s_nxt.global_irq_enable;
        // read data stand for one cycle only
        s_nxt.rd_data = RST_BYTE;
        if (rd_in)
        begin
            case (addr_in)
                ADDR_FLAGS_RUN:
                    s_nxt.rd_data = {s_r.timer1_overflow_flag,
                        s_r.timer1_run, s_r.timer0_overflow_flag,
                        s_r.timer0_run, 4'h0};
                ADDR_MODE_SEL:
                    s_nxt.rd_data = {1'b0, s_r.timer1_clock_select,
                        s_r.timer1_mode_field, s_r.timer0_pin_gating,
                        s_r.timer0_clock_select, s_r.timer0_mode_field};
                ADDR_T0_LOW: s_nxt.rd_data = s_r.timer0_count_low;
                ADDR_T1_LOW: s_nxt.rd_data = s_r.timer1_count_low;
                ADDR_T0_HIGH: s_nxt.rd_data = s_r.timer0_count_high;
                ADDR_T1_HIGH: s_nxt.rd_data = s_r.timer1_count_high;
                ADDR_IRQ_EN:
                    s_nxt.rd_data = {s_r.global_irq_enable, 3'h0,
                        s_r.timer1_irq_enable, 1'b0,
                        s_r.timer0_irq_enable, 1'b0};
                ADDR_EXT_DIV:
                    s_nxt.rd_data = {1'b0, s_r.timer0_ext_div_field,
                        1'b0, s_r.timer1_ext_div_field};
                default: s_nxt.rd_data = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            s_r <= '0;
        else if (ce_in)
            s_r <= s_nxt;
    end

    assign rd_data_out = s_r.rd_data;
    assign timer0_irq_req_out = s_r.irq0_req;
    assign timer1_irq_req_out = s_r.irq1_req;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    property p_t0_flag_set;
        ce_in && t0_ovf |=> s_r.timer0_overflow_flag;
    endproperty
    a_t0_flag_set: assert property (p_t0_flag_set)
        else $error("timer 0 overflow did not set flag");

    property p_t1_flag_set;
        ce_in && t1_ovf |=> s_r.timer1_overflow_flag;
    endproperty
    a_t1_flag_set: assert property (p_t1_flag_set)
        else $error("timer 1 overflow did not set flag");

    property p_ack_clear;
        ce_in && timer0_irq_ack_in && !t0_ovf && !wr_fr
            |=> !s_r.timer0_overflow_flag;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("service did not clear timer 0 flag");

    property p_stopped;
        ce_in && !s_r.timer0_run && !wr_t0_lo |=> $stable(s_r.timer0_count_low);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("timer 0 low byte moved while stopped");

    property p_reload;
        ce_in && t0_lo_en && !wr_t0_lo
            && (s_r.timer0_mode_field == MODE_RELOAD)
            && (s_r.timer0_count_low == BYTE_MAX)
        |=> s_r.timer0_count_low == $past(s_r.timer0_count_high)
            && s_r.timer0_overflow_flag;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload mode did not copy high byte");

    property p_13bit_top;
        ce_in && t0_lo_en && !wr_t0_lo && !wr_t0_hi
            && (s_r.timer0_mode_field == MODE_13BIT)
        |=> $stable(s_r.timer0_count_low[7:5]);
    endproperty
    a_13bit_top: assert property (p_13bit_top)
        else $error("13-bit mode touched top low bits");

    property p_rsv_read;
        ce_in && rd_in && (addr_in == ADDR_MODE_SEL)
        |=> !rd_data_out[7] ##1 rd_data_out == 8'h00 || $past(rd_in);
    endproperty
    a_rsv_read: assert property (p_rsv_read)
        else $error("reserved mode bit read nonzero");

    property p_hi_write;
        ce_in && wr_t0_hi |=> s_r.timer0_count_high == $past(wr_data_in);
    endproperty
    a_hi_write: assert property (p_hi_write)
        else $error("timer 0 high byte write lost");

    property p_irq_gate;
        !s_r.global_irq_enable && !(ce_in && wr_in) |=> !timer0_irq_req_out
            && !timer1_irq_req_out;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request raised with global enable low");

    c_reload: cover property (ce_in && t0_ovf
        && s_r.timer0_mode_field == MODE_RELOAD);
    c_split_hi: cover property (ce_in && t1_ovf
        && s_r.timer0_mode_field == MODE_SPLIT);
    c_ack: cover property (ce_in && timer0_irq_ack_in
        && s_r.timer0_overflow_flag);
    c_gate_hold: cover property (s_r.timer0_pin_gating
        && !ext_irq0_pin_in && s_r.timer0_run);

endmodule : tmr_dual_timer

// ### rtl/tmr_pkg.sv
package tmr_pkg;

    // ==========================================================
    // register offsets (byte addresses on the plain port)
    // ==========================================================
    localparam logic [7:0] ADDR_FLAGS_RUN = 8'h88;
    localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;
    localparam logic [7:0] ADDR_EXT_DIV = 8'hE7;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int FR_T1_FLAG = 7;
    localparam int FR_T1_RUN = 6;
    localparam int FR_T0_FLAG = 5;
    localparam int FR_T0_RUN = 4;
    localparam int MS_T1_CLK = 6;
    localparam int MS_T1_MODE = 4;
    localparam int MS_T0_GATE = 3;
    localparam int MS_T0_CLK = 2;
    localparam int MS_T0_MODE = 0;
    localparam int DV_T0_RATE = 4;
    localparam int DV_T1_RATE = 0;
    localparam int IE_GLOBAL = 7;
    localparam int IE_T1 = 3;
    localparam int IE_T0 = 1;

    // ==========================================================
    // reset values and counts
    // ==========================================================
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [4:0] LOW5_MAX = 5'h1F;
    localparam int CPU_DIV = 12;
    localparam int RATE_W = 3;
    localparam int OSC_CNT_W = 7;

    typedef enum logic [1:0]
    {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } tmr_mode_e;

endpackage : tmr_pkg

// ### rtl/tmr_prescale.sv
`timescale 1ns/1ps
module tmr_prescale
    import tmr_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic tick_in,
    input wire logic [tmr_pkg::RATE_W-1:0] rate_in,
    output logic tick_out
);
    import tmr_pkg::*;

    typedef struct packed
    {
        logic [OSC_CNT_W-1:0] cnt;
    } tmr_pre_s;

    tmr_pre_s state_r;
    tmr_pre_s state_nxt;
    logic [OSC_CNT_W-1:0] limit;

    // divide by 128 at code 0, halving per step, by 1 at the top code
    assign limit = OSC_CNT_W'((8'h80 >> rate_in) - 8'h01);
    assign tick_out = tick_in && (state_r.cnt >= limit);

    always_comb
    begin
        state_nxt = state_r;
        if (tick_in)
        begin
            if (state_r.cnt >= limit)
                state_nxt.cnt = '0;
            else
                state_nxt.cnt = state_r.cnt + OSC_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            state_r <= '0;
        else if (ce_in)
            state_r <= state_nxt;
    end

endmodule : tmr_prescale

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tmr_pkg::*;

    // ==========================================================
    // signals and design instance
    // ==========================================================
    localparam int PRE = 2;
    localparam int LIMIT = 20000;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic osc_tick_in = 1'b0;
    logic ext_irq0_pin_in = 1'b0;
    logic timer0_irq_ack_in = 1'b0;
    logic timer1_irq_ack_in = 1'b0;
    logic [7:0] rd_data_out;
    logic timer0_irq_req_out;
    logic timer1_irq_req_out;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] seen;
    logic [7:0] regs [8] = '{ADDR_FLAGS_RUN, ADDR_MODE_SEL, ADDR_T0_LOW,
        ADDR_T1_LOW, ADDR_T0_HIGH, ADDR_T1_HIGH, ADDR_IRQ_EN, ADDR_EXT_DIV};

    tmr_dual_timer #(.CPU_PRESCALE(PRE)) i_tmr_dual_timer (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .addr_in(addr_in),
        .wr_data_in(wr_data_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .osc_tick_in(osc_tick_in),
        .ext_irq0_pin_in(ext_irq0_pin_in),
        .timer0_irq_ack_in(timer0_irq_ack_in),
        .timer1_irq_ack_in(timer1_irq_ack_in),
        .rd_data_out(rd_data_out),
        .timer0_irq_req_out(timer0_irq_req_out),
        .timer1_irq_req_out(timer1_irq_req_out)
    );

    initial
    begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    // ==========================================================
    // compare, bus and stimulus tasks
    // ==========================================================
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %02h seen %02h", n, e, g);
        end
    endtask : chk_byte

    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_range(input string n, input int lo, input int hi,
                             input logic [7:0] g);
        checked++;
        if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1))
        begin
            err_total++;
            $display("[ERR] %s expected %0d..%0d seen %02h", n, lo, hi, g);
        end
    endtask : chk_range

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [7:0] e);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        seen = rd_data_out;
        chk_byte(n, e, seen);
    endtask : rchk

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk_in);
            osc_tick_in <= 1'b1;
            @(posedge ref_clk_in);
            osc_tick_in <= 1'b0;
        end
    endtask : tick

    task automatic chk_req(input string n, input int w, input logic e);
        @(negedge ref_clk_in);
        @(negedge ref_clk_in);
        chk_bit(n, e, (w == 1) ? timer1_irq_req_out : timer0_irq_req_out);
    endtask : chk_req

    task automatic ack(input int w);
        @(posedge ref_clk_in);
        if (w == 1)
            timer1_irq_ack_in <= 1'b1;
        else
            timer0_irq_ack_in <= 1'b1;
        @(posedge ref_clk_in);
        timer1_irq_ack_in <= 1'b0;
        timer0_irq_ack_in <= 1'b0;
    endtask : ack

    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            err_total++;
            finish_test();
        end
    end

    // ==========================================================
    // test sequence
    // ==========================================================
    initial
    begin
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++)
            rchk("reset value", regs[i], 8'h00);
        rchk("unmapped", 8'h00, 8'h00);
        $display("test reset_values done");

        wr(ADDR_MODE_SEL, 8'hFF);
        rchk("mode reserved", ADDR_MODE_SEL, 8'h7F);
        wr(ADDR_EXT_DIV, 8'hFF);
        rchk("div reserved", ADDR_EXT_DIV, 8'h77);
        wr(ADDR_IRQ_EN, 8'hFF);
        rchk("irq enables", ADDR_IRQ_EN, 8'h8A);
        wr(ADDR_FLAGS_RUN, 8'h0F);
        rchk("flags reserved", ADDR_FLAGS_RUN, 8'h00);
        wr(ADDR_MODE_SEL, 8'h00);
        wr(ADDR_IRQ_EN, 8'h00);
        for (int i = 2; i < 6; i++)
        begin
            wr(regs[i], 8'hA5 ^ 8'(i));
            rchk("count byte", regs[i], 8'hA5 ^ 8'(i));
        end
        @(posedge ref_clk_in);
        ce_in <= 1'b0;
        wr(ADDR_T0_HIGH, 8'h11);
        ce_in <= 1'b1;
        rchk("ce low write", ADDR_T0_HIGH, 8'hA1);
        $display("test register_access done");

        wr(ADDR_MODE_SEL, 8'h55);
        wr(ADDR_FLAGS_RUN, 8'h50);
        for (int k = 7; k >= 0; k--)
        begin
            wr(ADDR_EXT_DIV, {1'b0, 3'(k), 1'b0, 3'(k)});
            wr(ADDR_T0_LOW, 8'h00);
            wr(ADDR_T1_LOW, 8'h00);
            tick((128 >> k) - 1);
            rchk("t0 div early", ADDR_T0_LOW, 8'h00);
            rchk("t1 div early", ADDR_T1_LOW, 8'h00);
            tick(1);
            rchk("t0 div step", ADDR_T0_LOW, 8'h01);
            rchk("t1 div step", ADDR_T1_LOW, 8'h01);
        end
        $display("test dividers done");

        wr(ADDR_FLAGS_RUN, 8'h00);
        wr(ADDR_MODE_SEL, 8'h40);
        wr(ADDR_EXT_DIV, 8'h07);
        wr(ADDR_T1_HIGH, 8'h00);
        wr(ADDR_T1_LOW, 8'h1F);
        wr(ADDR_IRQ_EN, 8'h08);
        wr(ADDR_FLAGS_RUN, 8'h40);
        tick(1);
        rchk("13bit carry low", ADDR_T1_LOW, 8'h00);
        rchk("13bit carry high", ADDR_T1_HIGH, 8'h01);
        wr(ADDR_T1_HIGH, 8'hFF);
        wr(ADDR_T1_LOW, 8'h1F);
        tick(1);
        chk_req("req1 no global", 1, 1'b0);
        rchk("13bit wrap", ADDR_T1_HIGH, 8'h00);
        rchk("t1 flag", ADDR_FLAGS_RUN, 8'hC0);
        wr(ADDR_IRQ_EN, 8'h88);
        chk_req("req1 raised", 1, 1'b1);
        ack(1);
        chk_req("req1 after ack", 1, 1'b0);
        rchk("t1 flag acked", ADDR_FLAGS_RUN, 8'h40);
        $display("test mode_13bit done");

        wr(ADDR_FLAGS_RUN, 8'h00);
        wr(ADDR_MODE_SEL, 8'h06);
        wr(ADDR_EXT_DIV, 8'h70);
        wr(ADDR_T0_HIGH, 8'h80);
        wr(ADDR_T0_LOW, 8'hFF);
        wr(ADDR_IRQ_EN, 8'h82);
        wr(ADDR_FLAGS_RUN, 8'h10);
        tick(1);
        rchk("reload copy", ADDR_T0_LOW, 8'h80);
        chk_req("req0 raised", 0, 1'b1);
        rchk("only t0 flag", ADDR_FLAGS_RUN, 8'h30);
        tick(1);
        rchk("reload count", ADDR_T0_LOW, 8'h81);
        wr(ADDR_FLAGS_RUN, 8'h10);
        chk_req("req0 fw clear", 0, 1'b0);
        rchk("t0 flag cleared", ADDR_FLAGS_RUN, 8'h10);
        wr(ADDR_FLAGS_RUN, 8'h00);
        tick(1);
        rchk("stopped t0", ADDR_T0_LOW, 8'h81);
        $display("test reload done");

        wr(ADDR_MODE_SEL, 8'h0D);
        wr(ADDR_T0_LOW, 8'h00);
        wr(ADDR_FLAGS_RUN, 8'h10);
        tick(1);
        rchk("gated pin low", ADDR_T0_LOW, 8'h00);
        @(posedge ref_clk_in);
        ext_irq0_pin_in <= 1'b1;
        tick(1);
        rchk("gated pin high", ADDR_T0_LOW, 8'h01);
        @(posedge ref_clk_in);
        ext_irq0_pin_in <= 1'b0;
        wr(ADDR_MODE_SEL, 8'h05);
        tick(1);
        rchk("gate off", ADDR_T0_LOW, 8'h02);
        wr(ADDR_T0_HIGH, 8'hFF);
        wr(ADDR_T0_LOW, 8'hFF);
        tick(1);
        rchk("16bit wrap", ADDR_T0_HIGH, 8'h00);
        rchk("16bit flag", ADDR_FLAGS_RUN, 8'h30);
        ack(0);
        $display("test gating done");

        wr(ADDR_FLAGS_RUN, 8'h00);
        wr(ADDR_MODE_SEL, 8'h74);
        wr(ADDR_EXT_DIV, 8'h77);
        wr(ADDR_T1_LOW, 8'h00);
        wr(ADDR_T0_LOW, 8'hFF);
        wr(ADDR_FLAGS_RUN, 8'h50);
        tick(1);
        rchk("t1 mode 11", ADDR_T1_LOW, 8'h00);
        rchk("13bit top kept", ADDR_T0_LOW, 8'hE0);
        rchk("13bit t0 carry", ADDR_T0_HIGH, 8'h01);
        $display("test t1_reserved done");

        wr(ADDR_FLAGS_RUN, 8'h00);
        wr(ADDR_MODE_SEL, 8'h03);
        wr(ADDR_T0_HIGH, 8'h00);
        wr(ADDR_T0_LOW, 8'h00);
        wr(ADDR_T1_HIGH, 8'hFF);
        wr(ADDR_T1_LOW, 8'h00);
        wr(ADDR_FLAGS_RUN, 8'h40);
        repeat (80) @(posedge ref_clk_in);
        wr(ADDR_FLAGS_RUN, 8'h00);
        rchk("split low idle", ADDR_T0_LOW, 8'h00);
        @(posedge ref_clk_in);
        addr_in <= ADDR_T0_HIGH;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        chk_range("split high rate", 80 / PRE - 2, 84 / PRE + 1,
                  rd_data_out);
        rchk("t1 no flag", ADDR_FLAGS_RUN, 8'h00);
        wr(ADDR_T0_HIGH, 8'hFF);
        wr(ADDR_IRQ_EN, 8'h88);
        wr(ADDR_FLAGS_RUN, 8'h40);
        for (int i = 0; i < 100 && timer1_irq_req_out !== 1'b1; i++)
            @(posedge ref_clk_in);
        chk_req("split req1", 1, 1'b1);
        // stop the high byte but keep the timer 1 flag set
        wr(ADDR_FLAGS_RUN, 8'h80);
        rchk("split flag", ADDR_FLAGS_RUN, 8'h80);
        $display("test split done");
        finish_test();
    end

endmodule : tb_top
